// *** inc/pnp_pkg.sv ***
// Purpose: Constants and types of the parallel nonvolatile programming port
// Assumes: Pins already synchronous to clk_i, 125 MHz clock
// Notes: Names of pins, commands and fields are shared by all design files
package pnp_pkg;

    // ------------------------------------------------------------
    // Pin codes
    // ------------------------------------------------------------
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD = 2'h2;

    // ------------------------------------------------------------
    // Command bytes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_ERASE = 8'h80;
    localparam logic [7:0] CMD_WR_FUSE = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK = 8'h20;
    localparam logic [7:0] CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
    localparam logic [7:0] CMD_RD_SIG = 8'h08;
    localparam logic [7:0] CMD_RD_FUSE = 8'h04;
    localparam logic [7:0] CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] CMD_RD_EEPROM = 8'h03;

    // ------------------------------------------------------------
    // Widths and layout
    // ------------------------------------------------------------
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam int PAGE_WORDS = 64;
    localparam int WIDX_W = 6;
    localparam int PAGE_W = 7;
    localparam int HI_PAGE_W = 5;
    localparam int MADDR_W = 13;
    localparam int ADDR_LO_PAGE_MSB = 7;
    localparam int ADDR_LO_PAGE_LSB = 6;
    localparam logic [6:0] LAST_WIDX = 7'h3f;
    localparam logic [6:0] STREAM_END = 7'h40;

    // Fuse byte fields: boot vector 6, serial enable 5, brown-out level 4,
    // brown-out enable 3, clock source 2..0; bit 7 reserved at one
    localparam int FUSE_BOOT_RST = 6;
    localparam int FUSE_SER_EN = 5;
    localparam int FUSE_BO_LEVEL = 4;
    localparam int FUSE_BO_EN = 3;
    localparam logic [7:0] FUSE_RSV_MASK = 8'h80;
    // Lock byte: boot locks 5..2, memory locks 1..0, 7..6 reserved at one
    localparam logic [7:0] LOCK_RSV_MASK = 8'hc0;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    localparam logic [7:0] SIG_IDX0 = 8'h00;
    localparam logic [7:0] SIG_IDX1 = 8'h01;
    localparam logic [7:0] SIG_IDX2 = 8'h02;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ = 125000;
    localparam int T_ERASE_MS = 16;
    localparam int T_FLASH_MS = 8;
    localparam int T_BYTE_MS = 1;
    localparam int ERASE_CYC = T_ERASE_MS * CLK_KHZ;
    localparam int FLASH_CYC = T_FLASH_MS * CLK_KHZ;
    localparam int BYTE_CYC = T_BYTE_MS * CLK_KHZ;
    localparam int CNT_W = 22;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_STREAM,
        ST_WAIT
    } pnp_state_t;

endpackage

// *** inc/pnp_buf_if.sv ***
// Purpose: Link between port controller and page buffer memory
// Assumes: One clock, read data registered inside the buffer
// Notes: Byte enables select low or high half of a word
`timescale 1ns/10ps
interface pnp_buf_if;
    logic we;
    logic [1:0] be;
    logic [pnp_pkg::WIDX_W-1:0] waddr;
    logic [pnp_pkg::WORD_W-1:0] wdata;
    logic [pnp_pkg::WIDX_W-1:0] raddr;
    logic [pnp_pkg::WORD_W-1:0] rdata;

    modport ctrl (output we, output be, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input be, input waddr, input wdata, input raddr, output rdata);
endinterface

// *** src/pnp_page_buf.sv ***
// Purpose: Flash page buffer, 64 words of 16 bits
// Assumes: Writes by byte lane, read data one cycle after address
// Notes: Contents undefined after power up, as in the real buffer
`timescale 1ns/10ps
module pnp_page_buf (
    input wire logic clk_i,
    pnp_buf_if.mem buf_if
);
    wire [pnp_pkg::WORD_W-1:0] rdata_w;

    // ------------------------------------------------------------
    // Byte lanes
    // ------------------------------------------------------------
    // One array per lane, so each array has a single writing process
    for (genvar b = 0; b < pnp_pkg::WORD_W / pnp_pkg::BYTE_W; b++) begin : g_lane
        logic [pnp_pkg::BYTE_W-1:0] lane_q [pnp_pkg::PAGE_WORDS];
        logic [pnp_pkg::BYTE_W-1:0] lane_rd_q;
        always_ff @(posedge clk_i) begin
            if (buf_if.we && buf_if.be[b]) begin
                lane_q[buf_if.waddr] <= buf_if.wdata[b*pnp_pkg::BYTE_W +: pnp_pkg::BYTE_W];
            end
            lane_rd_q <= lane_q[buf_if.raddr];
        end
        assign rdata_w[b*pnp_pkg::BYTE_W +: pnp_pkg::BYTE_W] = lane_rd_q;
    end

    assign buf_if.rdata = rdata_w;
endmodule

// *** src/pnp_prog_port.sv ***
// Purpose: Parallel programming port of the nonvolatile memories
// Assumes: Pins synchronous to clk_i; array timing modelled by counters
// Notes: Array port writes one word per pulse; erase is a single pulse
`timescale 1ns/10ps
module pnp_prog_port #(
    parameter int unsigned ERASE_CYCLES = pnp_pkg::ERASE_CYC,
    parameter int unsigned FLASH_CYCLES = pnp_pkg::FLASH_CYC,
    parameter int unsigned BYTE_CYCLES = pnp_pkg::BYTE_CYC,
    parameter logic [7:0] FUSE_INIT = 8'hff,
    parameter logic [7:0] SIG_BYTE0 = 8'h5a, // Arbitrary value
    parameter logic [7:0] SIG_BYTE1 = 8'ha5, // Arbitrary value
    parameter logic [7:0] SIG_BYTE2 = 8'h3c  // Arbitrary value
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic prog_mode_i,
    input wire logic oscillator_load_pin_i,
    input wire logic action_select_hi_i,
    input wire logic action_select_lo_i,
    input wire logic byte_select_i,
    input wire logic page_load_strobe_i,
    input wire logic write_strobe_n_i,
    input wire logic output_enable_n_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    output logic ready_busy_n_o,
    output logic mem_we_o,
    output logic mem_eeprom_o,
    output logic mem_erase_o,
    output logic [pnp_pkg::MADDR_W-1:0] mem_addr_o,
    output logic [pnp_pkg::WORD_W-1:0] mem_wdata_o,
    input wire logic [pnp_pkg::WORD_W-1:0] mem_rdata_i,
    output logic [7:0] fuse_o,
    output logic [7:0] lock_o
);
    pnp_buf_if buf_if ();

    pnp_page_buf u_buf (
        .clk_i(clk_i),
        .buf_if(buf_if)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    pnp_pkg::pnp_state_t state_q;
    logic load_pin_q, page_pin_q, wr_pin_q;
    logic [7:0] cmd_q, addr_lo_q, addr_hi_q, data_lo_q, data_hi_q;
    logic [7:0] fuse_q, lock_q, rd_q;
    logic [6:0] idx_q;
    logic [pnp_pkg::CNT_W-1:0] cnt_q;
    logic erase_pend_q;
    logic mem_we_q, mem_erase_q, mem_eeprom_q;
    logic [pnp_pkg::MADDR_W-1:0] mem_addr_q;
    logic [pnp_pkg::WORD_W-1:0] mem_wdata_q;

    // ------------------------------------------------------------
    // Pin decode
    // ------------------------------------------------------------
    wire busy = (state_q != pnp_pkg::ST_IDLE);
    // Strobes taken only in mode and while ready, so a running job is safe
    wire accept = prog_mode_i && !busy;
    wire load_evt = accept && oscillator_load_pin_i && !load_pin_q;
    wire page_evt = accept && page_load_strobe_i && !page_pin_q;
    wire wr_evt = accept && !write_strobe_n_i && wr_pin_q;
    wire [1:0] act = {action_select_hi_i, action_select_lo_i};
    wire ld_addr = load_evt && (act == pnp_pkg::ACT_ADDR);
    wire ld_data = load_evt && (act == pnp_pkg::ACT_DATA);
    wire ld_cmd = load_evt && (act == pnp_pkg::ACT_CMD);

    wire is_erase = (cmd_q == pnp_pkg::CMD_ERASE);
    wire is_wr_flash = (cmd_q == pnp_pkg::CMD_WR_FLASH);
    wire is_wr_eeprom = (cmd_q == pnp_pkg::CMD_WR_EEPROM);
    wire is_wr_fuse = (cmd_q == pnp_pkg::CMD_WR_FUSE);
    wire is_wr_lock = (cmd_q == pnp_pkg::CMD_WR_LOCK);
    wire is_rd_sig = (cmd_q == pnp_pkg::CMD_RD_SIG);
    wire is_rd_fuse = (cmd_q == pnp_pkg::CMD_RD_FUSE);
    wire is_rd_flash = (cmd_q == pnp_pkg::CMD_RD_FLASH);
    wire is_rd_eeprom = (cmd_q == pnp_pkg::CMD_RD_EEPROM);
    wire is_read = is_rd_sig || is_rd_fuse || is_rd_flash || is_rd_eeprom;

    // Write pulse dispatch; the no-operation command matches nothing
    wire go_erase = wr_evt && is_erase;
    wire go_page = wr_evt && is_wr_flash;
    wire go_eeprom = wr_evt && is_wr_eeprom && !byte_select_i;
    wire go_fuse = wr_evt && is_wr_fuse;
    wire go_lock = wr_evt && is_wr_lock;

    // Page from high byte bits 4..0 and low byte bits 7..6
    wire [pnp_pkg::PAGE_W-1:0] page_num = {addr_hi_q[pnp_pkg::HI_PAGE_W-1:0],
        addr_lo_q[pnp_pkg::ADDR_LO_PAGE_MSB:pnp_pkg::ADDR_LO_PAGE_LSB]};
    // Shared word or byte address of the array while idle
    wire [pnp_pkg::MADDR_W-1:0] cur_addr = {addr_hi_q[pnp_pkg::HI_PAGE_W-1:0], addr_lo_q};
    wire [pnp_pkg::WIDX_W-1:0] idx_lo = idx_q[pnp_pkg::WIDX_W-1:0];
    wire stream_word = (state_q == pnp_pkg::ST_STREAM) && (idx_q != '0);

    // ------------------------------------------------------------
    // Page buffer access
    // ------------------------------------------------------------
    assign buf_if.we = page_evt;
    assign buf_if.be = byte_select_i ? 2'h2 : 2'h1;
    assign buf_if.waddr = addr_lo_q[pnp_pkg::WIDX_W-1:0];
    assign buf_if.wdata = {data_hi_q, data_lo_q};
    assign buf_if.raddr = idx_lo;

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    wire [7:0] sig_byte = (addr_lo_q == pnp_pkg::SIG_IDX0) ? SIG_BYTE0 :
                          (addr_lo_q == pnp_pkg::SIG_IDX1) ? SIG_BYTE1 :
                          (addr_lo_q == pnp_pkg::SIG_IDX2) ? SIG_BYTE2 :
                          pnp_pkg::ERASED_BYTE;
    wire [7:0] flash_byte = byte_select_i ? mem_rdata_i[pnp_pkg::WORD_W-1:pnp_pkg::BYTE_W] :
                                            mem_rdata_i[pnp_pkg::BYTE_W-1:0];
    wire [7:0] rd_d = is_rd_fuse ? (byte_select_i ? lock_q : fuse_q) :
                      is_rd_sig ? (byte_select_i ? pnp_pkg::ERASED_BYTE : sig_byte) :
                      is_rd_flash ? flash_byte :
                      mem_rdata_i[pnp_pkg::BYTE_W-1:0];

    assign data_o = rd_q;
    // Released whenever enable is high or no read is loaded
    assign data_oe_o = prog_mode_i && !output_enable_n_i && is_read;
    assign ready_busy_n_o = !busy;
    assign mem_we_o = mem_we_q;
    assign mem_eeprom_o = mem_eeprom_q;
    assign mem_erase_o = mem_erase_q;
    assign mem_addr_o = mem_addr_q;
    assign mem_wdata_o = mem_wdata_q;
    assign fuse_o = fuse_q;
    assign lock_o = lock_q;

    // ------------------------------------------------------------
    // Pin history and read register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            load_pin_q <= 1'b0;
            page_pin_q <= 1'b0;
            wr_pin_q <= 1'b1;
            rd_q <= 8'h00;
        end else begin
            load_pin_q <= oscillator_load_pin_i;
            page_pin_q <= page_load_strobe_i;
            wr_pin_q <= write_strobe_n_i;
            rd_q <= rd_d;
        end
    end

    // ------------------------------------------------------------
    // Loaded command, address and data
    // ------------------------------------------------------------
    // All kept until reloaded, so one command serves many accesses
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cmd_q <= pnp_pkg::CMD_NOP;
            addr_lo_q <= 8'h00;
            addr_hi_q <= 8'h00;
            data_lo_q <= 8'h00;
            data_hi_q <= 8'h00;
        end else begin
            if (ld_cmd) begin
                cmd_q <= data_i;
            end
            if (ld_addr && !byte_select_i) begin
                addr_lo_q <= data_i;
            end
            if (ld_addr && byte_select_i) begin
                addr_hi_q <= data_i;
            end
            if (ld_data && !byte_select_i) begin
                data_lo_q <= data_i;
            end
            if (ld_data && byte_select_i) begin
                data_hi_q <= data_i;
            end
        end
    end

    // ------------------------------------------------------------
    // Fuse and lock bytes
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            fuse_q <= FUSE_INIT | pnp_pkg::FUSE_RSV_MASK;
            lock_q <= pnp_pkg::ERASED_BYTE;
        end else begin
            if (go_fuse) begin
                fuse_q <= data_lo_q | pnp_pkg::FUSE_RSV_MASK;
            end
            // A lock write can only program bits, never release them
            if (go_lock) begin
                lock_q <= (lock_q & data_lo_q) | pnp_pkg::LOCK_RSV_MASK;
            end
            // Locks open only once the whole erase time has run out
            if (erase_pend_q && state_q == pnp_pkg::ST_WAIT && cnt_q == '0) begin
                lock_q <= pnp_pkg::ERASED_BYTE;
            end
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_q <= pnp_pkg::ST_IDLE;
            idx_q <= 7'h00;
            cnt_q <= '0;
            erase_pend_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_erase_q <= 1'b0;
            mem_eeprom_q <= 1'b0;
            mem_addr_q <= '0;
            mem_wdata_q <= '0;
        end else begin
            mem_we_q <= 1'b0;
            mem_erase_q <= 1'b0;
            case (state_q)
                pnp_pkg::ST_IDLE: begin
                    mem_addr_q <= cur_addr;
                    mem_eeprom_q <= is_rd_eeprom || is_wr_eeprom;
                    idx_q <= 7'h00;
                    if (go_erase) begin
                        // Flash and EEPROM cleared by the array; fuses untouched
                        mem_erase_q <= 1'b1;
                        erase_pend_q <= 1'b1;
                        cnt_q <= pnp_pkg::CNT_W'(ERASE_CYCLES - 1);
                        state_q <= pnp_pkg::ST_WAIT;
                    end else if (go_page) begin
                        mem_eeprom_q <= 1'b0;
                        idx_q <= 7'h01;
                        state_q <= pnp_pkg::ST_STREAM;
                    end else if (go_eeprom) begin
                        mem_we_q <= 1'b1;
                        mem_eeprom_q <= 1'b1;
                        mem_wdata_q <= {8'h00, data_lo_q};
                        cnt_q <= pnp_pkg::CNT_W'(BYTE_CYCLES - 1);
                        state_q <= pnp_pkg::ST_WAIT;
                    end else if (go_fuse || go_lock) begin
                        cnt_q <= pnp_pkg::CNT_W'(BYTE_CYCLES - 1);
                        state_q <= pnp_pkg::ST_WAIT;
                    end
                end
                pnp_pkg::ST_STREAM: begin
                    // Buffer read lags its address by one cycle
                    if (stream_word) begin
                        mem_we_q <= 1'b1;
                        mem_addr_q <= {page_num, 6'(idx_q - 7'h01)};
                        mem_wdata_q <= buf_if.rdata;
                    end
                    idx_q <= idx_q + 7'h01;
                    if (idx_q == pnp_pkg::STREAM_END) begin
                        cnt_q <= pnp_pkg::CNT_W'(FLASH_CYCLES - 1);
                        state_q <= pnp_pkg::ST_WAIT;
                    end
                end
                pnp_pkg::ST_WAIT: begin
                    if (cnt_q == '0) begin
                        erase_pend_q <= 1'b0;
                        state_q <= pnp_pkg::ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= pnp_pkg::ST_IDLE;
                end
            endcase
        end
    end
endmodule

// *** test/pnp_prog_port_properties.sv ***
// Purpose: Pin-level relations of the programming port
// Assumes: Bench shortens byte busy to five cycles, erase to twenty
// Notes: Shadows the loaded command and data low byte beside the design
`timescale 1ns/10ps
module pnp_prog_port_properties (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic prog_mode_i,
    input wire logic oscillator_load_pin_i,
    input wire logic action_select_hi_i,
    input wire logic action_select_lo_i,
    input wire logic byte_select_i,
    input wire logic write_strobe_n_i,
    input wire logic output_enable_n_i,
    input wire logic [7:0] data_i,
    input wire logic data_oe_o,
    input wire logic ready_busy_n_o,
    input wire logic mem_we_o,
    input wire logic mem_eeprom_o,
    input wire logic mem_erase_o,
    input wire logic [7:0] fuse_o,
    input wire logic [7:0] lock_o
);
    // ------------------------------------------------------------
    // Shadow of the loaded command
    // ------------------------------------------------------------
    logic ld_q, wr_q;
    logic [7:0] cmd_q, dlo_q;
    wire rdy_w = ready_busy_n_o & prog_mode_i;
    wire ld_w = rdy_w & oscillator_load_pin_i & !ld_q;
    wire take_w = rdy_w & !write_strobe_n_i & wr_q;
    wire rdcmd_w = cmd_q == 8'h04 || cmd_q == 8'h02 || cmd_q == 8'h03 || cmd_q == 8'h08;
    always_ff @(posedge clk_i) begin
        ld_q <= rst_b_i & oscillator_load_pin_i;
        wr_q <= !rst_b_i | write_strobe_n_i;
        if (!rst_b_i) begin
            cmd_q <= 8'h00;
            dlo_q <= 8'h00;
        end else if (ld_w && action_select_hi_i && !action_select_lo_i) begin
            cmd_q <= data_i;
        end else if (ld_w && !action_select_hi_i && action_select_lo_i && !byte_select_i) begin
            dlo_q <= data_i;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_bus_drive_rule: assert property (data_oe_o == (prog_mode_i & !output_enable_n_i & rdcmd_w))
        else $error("bus drive does not follow enable and read command");
    a_erase_start: assert property (take_w && cmd_q == 8'h80 |=> mem_erase_o && !ready_busy_n_o)
        else $error("erase did not start");
    a_erase_lock_clear: assert property (take_w && cmd_q == 8'h80 |=>
        (!ready_busy_n_o)[*8] ##[1:20] (ready_busy_n_o && lock_o == 8'hff))
        else $error("erase end without cleared locks");
    a_page_stream: assert property (take_w && cmd_q == 8'h10 |-> ##2 mem_we_o[*8])
        else $error("page write did not stream");
    a_eeprom_write: assert property (take_w && cmd_q == 8'h11 && !byte_select_i |=>
        mem_we_o && mem_eeprom_o)
        else $error("eeprom byte not written");
    a_fuse_store: assert property (take_w && cmd_q == 8'h40 |=> fuse_o == ($past(dlo_q) | 8'h80))
        else $error("fuse byte not stored");
    a_byte_busy: assert property (take_w && cmd_q == 8'h40 |=>
        (!ready_busy_n_o)[*5] ##[1:8] ready_busy_n_o)
        else $error("fuse write busy time wrong");
    a_nop_idle: assert property (take_w && cmd_q == 8'h00 |=> ready_busy_n_o && !mem_we_o)
        else $error("no-operation command started a write");
    a_busy_ignore: assert property (!ready_busy_n_o && !write_strobe_n_i && wr_q |=>
        !mem_erase_o && $stable(fuse_o))
        else $error("strobe acted while busy");
    a_lock_sticky: assert property (ready_busy_n_o && $past(ready_busy_n_o) |->
        (lock_o & ~$past(lock_o)) == 8'h00)
        else $error("lock bit unprogrammed without erase");
    a_lock_reserved: assert property (lock_o[7:6] == 2'b11)
        else $error("lock reserved bits not one");
    c_erase: cover property (take_w && cmd_q == 8'h80);
    c_page: cover property (take_w && cmd_q == 8'h10);
    c_eeprom: cover property (take_w && cmd_q == 8'h11);
endmodule

// *** test/pnp_mem_model.sv ***
// Purpose: Flash and EEPROM arrays behind the array port
// Assumes: Word-wide flash, byte-wide EEPROM, same address space size
// Notes: Read is combinational, as the port expects
`timescale 1ns/10ps
module pnp_mem_model (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic eeprom_i,
    input wire logic erase_i,
    input wire logic [12:0] addr_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] rdata_o
);
    logic [15:0] flash_m [8192];
    logic [7:0] eep_m [8192];
    always @(posedge clk_i) begin
        for (int i = 0; i < 8192; i++) begin
            if (erase_i) begin
                flash_m[i] = 16'hffff;
                eep_m[i] = 8'hff;
            end
        end
        if (we_i && eeprom_i) begin
            eep_m[addr_i] = wdata_i[7:0];
        end else if (we_i) begin
            flash_m[addr_i] = wdata_i;
        end
    end
    initial begin
        for (int i = 0; i < 8192; i++) begin
            flash_m[i] = 16'hffff;
            eep_m[i] = 8'hff;
        end
    end
    always_comb rdata_o = eeprom_i ? {8'h00, eep_m[addr_i]} : flash_m[addr_i];
endmodule

// *** test/tb_parallel_nvm_programming_port.sv ***
// Purpose: Self-checking bench of the programming port
// Assumes: Shortened busy counts; pins driven on the rising edge
// Notes: Expected reads and array writes queue up; a monitor pops them
`timescale 1ns/10ps
bind pnp_prog_port pnp_prog_port_properties u_pnp_prog_port_properties (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .prog_mode_i(prog_mode_i), .oscillator_load_pin_i(oscillator_load_pin_i),
    .action_select_hi_i(action_select_hi_i), .action_select_lo_i(action_select_lo_i),
    .byte_select_i(byte_select_i), .write_strobe_n_i(write_strobe_n_i),
    .output_enable_n_i(output_enable_n_i), .data_i(data_i), .data_oe_o(data_oe_o),
    .ready_busy_n_o(ready_busy_n_o), .mem_we_o(mem_we_o), .mem_eeprom_o(mem_eeprom_o),
    .mem_erase_o(mem_erase_o), .fuse_o(fuse_o), .lock_o(lock_o));
module tb_parallel_nvm_programming_port;
    logic clk_i = 0, rst_b_i = 0, mode = 0, ld = 0, axh = 0, axl = 0, bs = 0, pgl = 0;
    logic wr_n = 1, oe_n = 1, samp = 0, ee, er, we, doe, rdy;
    logic [7:0] din = 0, dout, fuse, lock, r, fz, hi, lo;
    logic [12:0] maddr;
    logic [15:0] mwd, mrd;
    logic [15:0] pg [64];
    logic [7:0] rq [$];
    logic [29:0] wq [$];
    int error_cnt = 0, n_checks = 0, cyc = 0;
    integer seed = 32'h0bd0;
    // Signature values arbitrary; byte 2 keeps its arbitrary default
    pnp_prog_port #(.ERASE_CYCLES(20), .FLASH_CYCLES(10), .BYTE_CYCLES(5), .SIG_BYTE0(8'h61),
        .SIG_BYTE1(8'h62)) u_pnp_prog_port (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .prog_mode_i(mode), .oscillator_load_pin_i(ld), .action_select_hi_i(axh),
        .action_select_lo_i(axl), .byte_select_i(bs), .page_load_strobe_i(pgl),
        .write_strobe_n_i(wr_n), .output_enable_n_i(oe_n), .data_i(din), .data_o(dout),
        .data_oe_o(doe), .ready_busy_n_o(rdy), .mem_we_o(we), .mem_eeprom_o(ee),
        .mem_erase_o(er), .mem_addr_o(maddr), .mem_wdata_o(mwd), .mem_rdata_i(mrd),
        .fuse_o(fuse), .lock_o(lock));
    pnp_mem_model u_pnp_mem_model (.clk_i(clk_i), .we_i(we), .eeprom_i(ee), .erase_i(er),
        .addr_i(maddr), .wdata_i(mwd), .rdata_o(mrd));
    initial forever #4 clk_i = ~clk_i;
    // ------------------------------------------------------------
    // Pin tasks and comparisons
    // ------------------------------------------------------------
    task automatic cmp8(input logic [7:0] e, input logic [7:0] a);
        n_checks++;
        if (a !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t byte exp %h got %h", $time, e, a);
        end
    endtask
    task automatic cmp30(input logic [29:0] e, input logic [29:0] a);
        n_checks++;
        if (a !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t array write exp %h got %h", $time, e, a);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic load(input logic [1:0] a, input logic b, input logic [7:0] d);
        @(posedge clk_i);
        axh <= a[1];
        axl <= a[0];
        bs <= b;
        din <= d;
        ld <= 1;
        @(posedge clk_i);
        ld <= 0;
    endtask
    task automatic pstrobe(input logic b);
        @(posedge clk_i);
        bs <= b;
        pgl <= 1;
        @(posedge clk_i);
        pgl <= 0;
    endtask
    task automatic wstrobe();
        @(posedge clk_i);
        bs <= 0;
        wr_n <= 0;
        @(posedge clk_i);
        wr_n <= 1;
    endtask
    task automatic waitrdy();
        tick(2);
        for (int k = 0; k < 500 && rdy !== 1'b1; k++) @(posedge clk_i);
    endtask
    task automatic rd(input logic b, input logic [7:0] e);
        @(posedge clk_i);
        oe_n <= 0;
        bs <= b;
        tick(3);
        rq.push_back(e);
        samp <= 1;
        @(posedge clk_i);
        samp <= 0;
        oe_n <= 1;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (samp) begin
            cmp8(rq.pop_front(), dout);
            cmp8(8'h01, {7'h0, doe});
        end
        if (we) cmp30(wq.pop_front(), {ee, maddr, mwd});
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        tick(4);
        rst_b_i <= 1;
        // Select low for 500 ns before mode entry, then 500 ns settle
        tick(63);
        mode <= 1;
        tick(63);
        cmp8(8'hff, fuse);
        cmp8(8'h01, {7'h0, rdy});
        load(2'h2, 0, pnp_pkg::CMD_ERASE);
        wstrobe();
        wstrobe();
        waitrdy();
        load(2'h2, 0, pnp_pkg::CMD_RD_SIG);
        for (int i = 0; i < 4; i++) begin
            load(2'h0, 0, 8'(i));
            rd(0, i < 2 ? 8'h61 + 8'(i) : i == 2 ? 8'h3c : 8'hff);
        end
        fz = 8'($random(seed)) | 8'h80;
        load(2'h2, 0, pnp_pkg::CMD_WR_FUSE);
        load(2'h1, 0, fz);
        wstrobe();
        waitrdy();
        load(2'h2, 0, pnp_pkg::CMD_WR_LOCK);
        load(2'h1, 0, 8'h0f);
        wstrobe();
        waitrdy();
        load(2'h1, 0, 8'hff);
        wstrobe();
        waitrdy();
        load(2'h2, 0, pnp_pkg::CMD_RD_FUSE);
        load(2'h3, 0, pnp_pkg::CMD_ERASE);
        rd(0, fz | 8'h80);
        rd(1, 8'hcf);
        hi = 8'($random(seed)) & 8'h1f;
        lo = 8'($random(seed));
        load(2'h2, 0, pnp_pkg::CMD_WR_FLASH);
        for (int w = 0; w < 64; w++) begin
            pg[w] = 16'($random(seed));
            load(2'h0, 0, {lo[7:6], 6'(w)});
            load(2'h1, 0, pg[w][7:0]);
            pstrobe(0);
            load(2'h1, 1, pg[w][15:8]);
            pstrobe(1);
        end
        load(2'h0, 1, hi);
        for (int k = 0; k < 2; k++) begin
            for (int w = 0; w < 64; w++) wq.push_back({1'b0, hi[4:0], lo[7:6], 6'(w), pg[w]});
            wstrobe();
            load(2'h2, 0, pnp_pkg::CMD_ERASE);
            waitrdy();
        end
        load(2'h2, 0, pnp_pkg::CMD_NOP);
        wstrobe();
        tick(2);
        cmp8(8'h01, {7'h0, rdy});
        load(2'h2, 0, pnp_pkg::CMD_RD_FLASH);
        load(2'h0, 0, {lo[7:6], 6'h05});
        rd(0, pg[5][7:0]);
        rd(1, pg[5][15:8]);
        r = 8'($random(seed));
        load(2'h2, 0, pnp_pkg::CMD_WR_EEPROM);
        load(2'h0, 0, lo);
        load(2'h1, 0, r);
        wq.push_back({1'b1, hi[4:0], lo, 8'h00, r});
        wstrobe();
        waitrdy();
        load(2'h2, 0, pnp_pkg::CMD_RD_EEPROM);
        rd(0, r);
        load(2'h2, 0, pnp_pkg::CMD_ERASE);
        wstrobe();
        waitrdy();
        cmp8(8'hff, lock);
        cmp8(fz | 8'h80, fuse);
        load(2'h2, 0, pnp_pkg::CMD_RD_FLASH);
        rd(0, 8'hff);
        complete_run();
    end
endmodule
